// ===== include/isp_pkg.sv
// constants for the two-wire in-system flash programming slave
// assumes one 250 MHz clock; the bus pins and flash array sit outside
package isp_pkg;
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          HANDOVER_MIN_NS  = 15000;
  localparam int          HANDOVER_CYCLES  = (HANDOVER_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          PROG_TIME_NS     = 60000;
  localparam int          PROG_CYCLES      = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          ERASE_TIME_US    = 4000;
  localparam int          ERASE_CYCLES     = (ERASE_TIME_US * 1000 / CLK_PERIOD_PS) * 1000;
  localparam int          TMR_W            = 20;
  localparam int          HAND_W           = 12;
  localparam logic [7:0]  UNLOCK_VALUE     = 8'h93;
  localparam logic [15:0] CRC_SEED         = 16'hFFFF;
  localparam logic [7:0]  TX_FILL          = 8'hFF;
  localparam logic [1:0]  TYPE_CMD_WR      = 2'h2;
  localparam logic [1:0]  TYPE_CMD_RD      = 2'h3;
  localparam logic [1:0]  TYPE_DATA_WR     = 2'h0;
  localparam logic [1:0]  TYPE_DATA_RD     = 2'h1;
  localparam logic [4:0]  CMD_PROGRAM      = 5'h14;
  localparam logic [4:0]  CMD_PAGE_ERASE   = 5'h06;
  localparam logic [4:0]  CMD_BLANK        = 5'h0D;
  localparam logic [4:0]  CMD_CLR_CRC      = 5'h1A;
  localparam logic [4:0]  CMD_RESET_CPU    = 5'h09;
  localparam logic [3:0]  IDX_LOW_ADDR     = 4'h1;
  localparam logic [3:0]  IDX_PAGE         = 4'h2;
  localparam logic [3:0]  IDX_FIRST_DATA   = 4'h2;
  typedef enum logic [2:0] {
    ISP_IDLE, ISP_ADDR, ISP_RX, ISP_ACK, ISP_TX, ISP_HACK
  } isp_state_t;
endpackage

// ===== hdl/isp_flash_prog.sv
// two-wire in-system programming slave with flash sequencer
// assumes scl/sda arrive asynchronously and the flash array takes a
// write through a valid/ready port and reads combinationally
module isp_flash_prog import isp_pkg::*; #(
  parameter int PROG_CYC  = PROG_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        slave_addr_wr,
  input  wire logic [5:0]  slave_addr_data,
  input  wire logic        unlock_wr,
  input  wire logic [7:0]  unlock_data,
  output logic             isp_active,
  output logic             cpu_reset,
  output logic             flash_wr_valid,
  input  wire logic        flash_wr_ready,
  output logic [15:0]      flash_wr_addr,
  output logic [7:0]       flash_wr_data,
  output logic             flash_erase_page,
  output logic             flash_erase_all,
  output logic [15:0]      flash_erase_addr,
  output logic [15:0]      flash_rd_addr,
  input  wire logic [7:0]  flash_rd_data
);
  // pin synchronisers
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
  assign bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign bus_stop  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  // firmware side: slave address, unlock and handover delay
  logic [5:0]        prog_slave_address_register_reg, prog_slave_address_register_next;
  logic              prog_unlock_register_reg, prog_unlock_register_next;
  logic [HAND_W-1:0] hand_cnt_reg, hand_cnt_next;
  logic              isp_active_reg, isp_active_next;
  logic              leave_isp;
  always_comb begin
    prog_slave_address_register_next = prog_slave_address_register_reg;
    prog_unlock_register_next        = prog_unlock_register_reg;
    hand_cnt_next                    = hand_cnt_reg;
    isp_active_next                  = isp_active_reg;
    if (slave_addr_wr)
      prog_slave_address_register_next = slave_addr_data;
    if (prog_unlock_register_reg && !isp_active_reg) begin
      if (hand_cnt_reg == HAND_W'(HANDOVER_CYCLES - 1))
        isp_active_next = 1'b1;
      else
        hand_cnt_next = hand_cnt_reg + 1'b1;
    end
    if (leave_isp) begin
      prog_unlock_register_next = 1'b0;
      isp_active_next           = 1'b0;
      hand_cnt_next             = '0;
    end
    if (unlock_wr && unlock_data == UNLOCK_VALUE)
      prog_unlock_register_next = 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prog_slave_address_register_reg <= '0;
      prog_unlock_register_reg        <= 1'b0;
      hand_cnt_reg                    <= '0;
      isp_active_reg                  <= 1'b0;
    end else begin
      prog_slave_address_register_reg <= prog_slave_address_register_next;
      prog_unlock_register_reg        <= prog_unlock_register_next;
      hand_cnt_reg                    <= hand_cnt_next;
      isp_active_reg                  <= isp_active_next;
    end
  end
  assign isp_active = isp_active_reg;
  // two-entry program buffer toward the flash
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W     = 24;
  logic [BUF_W-1:0] buf_reg [BUF_DEPTH];
  logic [BUF_W-1:0] buf_next [BUF_DEPTH];
  logic             wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0]       fill_reg, fill_next;
  logic             buf_push, buf_full;
  logic [BUF_W-1:0] push_word;
  assign buf_full       = (fill_reg == 2'(BUF_DEPTH));
  assign flash_wr_valid = (fill_reg != 2'h0);
  assign flash_wr_addr  = buf_reg[rd_ptr_reg][23:8];
  assign flash_wr_data  = buf_reg[rd_ptr_reg][7:0];
  always_comb begin
    buf_next    = buf_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    fill_next   = fill_reg;
    if (buf_push) begin
      buf_next[wr_ptr_reg] = push_word;
      wr_ptr_next          = ~wr_ptr_reg;
    end
    if (flash_wr_valid && flash_wr_ready)
      rd_ptr_next = ~rd_ptr_reg;
    fill_next = fill_reg + 2'(buf_push) - 2'(flash_wr_valid && flash_wr_ready);
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < BUF_DEPTH; i++)
        buf_reg[i] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= '0;
    end else begin
      buf_reg    <= buf_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      fill_reg   <= fill_next;
    end
  end
  // checksum step over one byte, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14] ^ fb, c[13:2], c[1] ^ fb, c[0], fb};
    end
    return c;
  endfunction
  // bus protocol engine
  isp_state_t       state_reg, state_next;
  logic [3:0]       bit_cnt_reg, bit_cnt_next, idx_reg, idx_next, idx_inc;
  logic [7:0]       sh_reg, sh_next, cmd_reg, cmd_next, page_reg, page_next, low_reg, low_next;
  logic [1:0]       type_reg, type_next;
  logic             ack_reg, ack_next, hnack_reg, hnack_next, cpu_reset_reg, cpu_reset_next;
  logic [15:0]      crc_reg, crc_next, erase_addr_reg, erase_addr_next;
  logic [TMR_W-1:0] prog_cnt_reg, prog_cnt_next, erase_cnt_reg, erase_cnt_next;
  logic             er_page_reg, er_page_next, er_all_reg, er_all_next;
  logic [7:0]       tx_byte;
  assign idx_inc = (idx_reg == 4'hF) ? idx_reg : idx_reg + 4'h1;
  always_comb begin
    case (idx_inc)
      4'h1:    tx_byte = cmd_reg;
      4'h2:    tx_byte = page_reg;
      4'h3:    tx_byte = low_reg;
      4'h4:    tx_byte = crc_reg[15:8];
      4'h5:    tx_byte = crc_reg[7:0];
      default: tx_byte = TX_FILL;
    endcase
    if (type_reg == TYPE_DATA_RD)
      tx_byte = flash_rd_data;
  end
  always_comb begin
    state_next      = state_reg;
    bit_cnt_next    = bit_cnt_reg;
    idx_next        = idx_reg;
    sh_next         = sh_reg;
    cmd_next        = cmd_reg;
    page_next       = page_reg;
    low_next        = low_reg;
    type_next       = type_reg;
    ack_next        = ack_reg;
    hnack_next      = hnack_reg;
    crc_next        = crc_reg;
    erase_addr_next = erase_addr_reg;
    prog_cnt_next   = (prog_cnt_reg != '0) ? prog_cnt_reg - 1'b1 : prog_cnt_reg;
    erase_cnt_next  = (erase_cnt_reg != '0) ? erase_cnt_reg - 1'b1 : erase_cnt_reg;
    cpu_reset_next  = 1'b0;
    er_page_next    = 1'b0;
    er_all_next     = 1'b0;
    buf_push        = 1'b0;
    push_word       = {page_reg, low_reg, sh_reg};
    if (bus_start) begin
      state_next   = ISP_ADDR;
      bit_cnt_next = '0;
      idx_next     = '0;
    end else if (bus_stop) begin
      state_next = ISP_IDLE;
    end else begin
      unique case (state_reg)
        ISP_IDLE: ;
        ISP_ADDR, ISP_RX: begin
          if (scl_rise) begin
            sh_next      = {sh_reg[6:0], sda_sync_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            state_next   = ISP_ACK;
            bit_cnt_next = '0;
            ack_next     = 1'b0;
            if (erase_cnt_reg != '0) begin
              ack_next = 1'b0;
            end else if (state_reg == ISP_ADDR) begin
              ack_next  = isp_active_reg &&
                          sh_reg[7:2] == prog_slave_address_register_reg;
              type_next = sh_reg[1:0];
            end else if (type_reg == TYPE_CMD_WR) begin
              if (idx_reg == IDX_LOW_ADDR) begin
                cmd_next = sh_reg;
                ack_next = 1'b1;
                if (sh_reg[7:3] == CMD_CLR_CRC)
                  crc_next = CRC_SEED;
                if (sh_reg[7:3] == CMD_RESET_CPU)
                  cpu_reset_next = 1'b1;
              end else if (idx_reg == IDX_PAGE) begin
                page_next = sh_reg;
                ack_next  = 1'b1;
              end
            end else if (type_reg == TYPE_DATA_WR) begin
              if (idx_reg == IDX_LOW_ADDR) begin
                low_next = sh_reg;
                ack_next = 1'b1;
              end else if (cmd_reg[7:3] == CMD_PROGRAM) begin
                if (prog_cnt_reg == '0 && !buf_full) begin
                  buf_push      = 1'b1;
                  ack_next      = 1'b1;
                  crc_next      = crc_byte(crc_reg, sh_reg);
                  low_next      = low_reg + 8'h01;
                  prog_cnt_next = TMR_W'(PROG_CYC);
                end
              end else if ((cmd_reg[7:3] == CMD_PAGE_ERASE ||
                            cmd_reg[7:3] == CMD_BLANK) && idx_reg == IDX_FIRST_DATA) begin
                er_page_next    = (cmd_reg[7:3] == CMD_PAGE_ERASE);
                er_all_next     = (cmd_reg[7:3] == CMD_BLANK);
                erase_addr_next = {page_reg, low_reg[7], 7'h00};
                erase_cnt_next  = TMR_W'(ERASE_CYC);
                ack_next        = 1'b1;
                low_next        = low_reg + 8'h01;
              end
            end
          end
        end
        ISP_ACK: begin
          if (scl_fall) begin
            idx_next = idx_inc;
            if (!ack_reg) begin
              state_next = ISP_IDLE;
            end else if (idx_reg == '0 && type_reg[0]) begin
              state_next = ISP_TX;
              sh_next    = tx_byte;
              if (type_reg == TYPE_DATA_RD)
                low_next = low_reg + 8'h01;
            end else begin
              state_next = ISP_RX;
            end
          end
        end
        ISP_TX: begin
          if (scl_fall) begin
            sh_next      = {sh_reg[6:0], 1'b1};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              state_next   = ISP_HACK;
              bit_cnt_next = '0;
            end
          end
        end
        ISP_HACK: begin
          if (scl_rise)
            hnack_next = sda_sync_reg;
          if (scl_fall) begin
            idx_next = idx_inc;
            if (type_reg == TYPE_DATA_RD && !hnack_reg)
              low_next = low_reg + 8'h01;
            if (hnack_reg) begin
              state_next = ISP_IDLE;
            end else begin
              state_next = ISP_TX;
              sh_next    = tx_byte;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg      <= ISP_IDLE;
      bit_cnt_reg    <= '0;
      idx_reg        <= '0;
      sh_reg         <= '0;
      cmd_reg        <= '0;
      page_reg       <= '0;
      low_reg        <= '0;
      type_reg       <= '0;
      ack_reg        <= 1'b0;
      hnack_reg      <= 1'b0;
      crc_reg        <= CRC_SEED;
      erase_addr_reg <= '0;
      prog_cnt_reg   <= '0;
      erase_cnt_reg  <= '0;
      cpu_reset_reg  <= 1'b0;
      er_page_reg    <= 1'b0;
      er_all_reg     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      bit_cnt_reg    <= bit_cnt_next;
      idx_reg        <= idx_next;
      sh_reg         <= sh_next;
      cmd_reg        <= cmd_next;
      page_reg       <= page_next;
      low_reg        <= low_next;
      type_reg       <= type_next;
      ack_reg        <= ack_next;
      hnack_reg      <= hnack_next;
      crc_reg        <= crc_next;
      erase_addr_reg <= erase_addr_next;
      prog_cnt_reg   <= prog_cnt_next;
      erase_cnt_reg  <= erase_cnt_next;
      cpu_reset_reg  <= cpu_reset_next;
      er_page_reg    <= er_page_next;
      er_all_reg     <= er_all_next;
    end
  end
  assign leave_isp        = cpu_reset_reg;
  assign cpu_reset        = cpu_reset_reg;
  assign flash_erase_page = er_page_reg;
  assign flash_erase_all  = er_all_reg;
  assign flash_erase_addr = erase_addr_reg;
  assign flash_rd_addr    = {page_reg, low_reg};
  assign sda_out          = 1'b0;
  assign sda_oe_n         = ~((state_reg == ISP_ACK && ack_reg) ||
                              (state_reg == ISP_TX && !sh_reg[7]));
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  unlock_value_a: assert property ($rose(prog_unlock_register_reg) |->
    $past(unlock_wr) && $past(unlock_data) == UNLOCK_VALUE)
    else $error("unlock taken without the unlock value");
  handover_delay_a: assert property ($rose(isp_active_reg) |->
    $past(hand_cnt_reg) == HAND_W'(HANDOVER_CYCLES - 1))
    else $error("handover before its delay");
  erase_refuse_a: assert property ($rose(state_reg == ISP_ACK) &&
    $past(erase_cnt_reg) != '0 |-> sda_oe_n && !ack_reg)
    else $error("ack given during erase");
  prog_busy_a: assert property (buf_push |-> prog_cnt_reg == '0 ##1
    prog_cnt_reg == TMR_W'(PROG_CYC))
    else $error("program byte taken while busy");
  addr_step_a: assert property (buf_push |=> low_reg == $past(low_reg) + 8'h01)
    else $error("low address did not step");
  crc_clear_a: assert property (state_reg == ISP_RX && type_reg == TYPE_CMD_WR &&
    idx_reg == IDX_LOW_ADDR && scl_fall && bit_cnt_reg == 4'h8 &&
    erase_cnt_reg == '0 && sh_reg[7:3] == CMD_CLR_CRC |=> crc_reg == CRC_SEED)
    else $error("checksum not preset");
  erase_start_a: assert property ($rose(erase_cnt_reg != '0) |->
    er_page_reg || er_all_reg)
    else $error("erase timer without erase pulse");
  prog_addr_a: assert property (buf_push && fill_reg == 2'h0 |=>
    flash_wr_addr == {$past(page_reg), $past(low_reg)} && flash_wr_data == $past(sh_reg))
    else $error("program address wrong");
  crc_only_prog_a: assert property (crc_reg != $past(crc_reg) |->
    $past(buf_push) || crc_reg == CRC_SEED)
    else $error("checksum moved without program byte");
endmodule // isp_flash_prog

// ===== testbench/isp_host_model.sv
// two-wire programming host model: drives the bus clock and data
// assumes the bench resolves the open-drain data wire with a pull-up
module isp_host_model (
  input  wire logic sys_clk,
  input  wire logic sda_wire,
  output logic      scl_drv,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one bit: data set well after the clock falls, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    wt(5);
    sda_drv = b;
    wt(15);
    scl_drv = 1'b1;
    wt(20);
    r = sda_wire;
    scl_drv = 1'b0;
  endtask
  // start, or repeated start when the clock is low
  task automatic start();
    wt(5);
    sda_drv = 1'b1;
    wt(15);
    scl_drv = 1'b1;
    wt(20);
    sda_drv = 1'b0;
    wt(20);
    scl_drv = 1'b0;
  endtask
  task automatic stop();
    wt(5);
    sda_drv = 1'b0;
    wt(15);
    scl_drv = 1'b1;
    wt(20);
    sda_drv = 1'b1;
    wt(20);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic hack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~hack, r);
  endtask
endmodule // isp_host_model

// ===== testbench/tb_i2c_isp_flash_programmer.sv
// self-checking bench for the two-wire flash programming slave
// assumes isp_host_model as bus master; flash is modelled here
module tb_i2c_isp_flash_programmer import isp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] SADDR = 6'h2a;
  logic        sys_clk, rst_n, scl_drv, sda_drv, sda_out, sda_oe_n;
  logic        slave_addr_wr, unlock_wr, isp_active, cpu_reset;
  logic        flash_wr_valid, flash_wr_ready, flash_erase_page, flash_erase_all;
  logic [5:0]  slave_addr_data;
  logic [7:0]  unlock_data, flash_wr_data, flash_rd_data;
  logic [15:0] flash_wr_addr, flash_erase_addr, flash_rd_addr;
  logic [16:0] er_last;
  logic [23:0] wr_q[$];
  int          n_errors, cmp_count, rst_cnt, er_cnt;
  wire         sda_wire = sda_drv & (sda_oe_n | sda_out);
  assign flash_rd_data = flash_rd_addr[7:0] ^ 8'h5a;
  isp_flash_prog #(.PROG_CYC(500), .ERASE_CYC(2000)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_drv), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .slave_addr_wr(slave_addr_wr),
    .slave_addr_data(slave_addr_data), .unlock_wr(unlock_wr),
    .unlock_data(unlock_data), .isp_active(isp_active), .cpu_reset(cpu_reset),
    .flash_wr_valid(flash_wr_valid), .flash_wr_ready(flash_wr_ready),
    .flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data),
    .flash_erase_page(flash_erase_page), .flash_erase_all(flash_erase_all),
    .flash_erase_addr(flash_erase_addr), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data));
  isp_host_model host_u (.sys_clk(sys_clk), .sda_wire(sda_wire),
    .scl_drv(scl_drv), .sda_drv(sda_drv));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // flash side: log accepted writes, erase pulses and processor resets
  always @(posedge sys_clk) begin
    if (flash_wr_valid && flash_wr_ready) wr_q.push_back({flash_wr_addr, flash_wr_data});
    if (flash_erase_page || flash_erase_all) begin
      er_last = {flash_erase_all, flash_erase_addr};
      er_cnt++;
    end
    if (cpu_reset) rst_cnt++;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // address byte then n bytes, each ack compared; gap spaces the bytes
  task automatic wr_seq(input logic [1:0] tt, input logic [7:0] b[4], input int n,
                        input logic [7:0] ea, input int gap);
    logic a;
    host_u.start();
    host_u.wr_byte({SADDR, tt}, a);
    chk(24'(a), 24'(ea[0]));
    for (int i = 0; i < n; i++) begin
      host_u.wt(gap);
      host_u.wr_byte(b[i], a);
      chk(24'(a), 24'(ea[i+1]));
    end
  endtask
  task automatic rd_seq(input logic [1:0] tt, input logic [7:0] e[5], input int n);
    logic       a;
    logic [7:0] d;
    host_u.start();
    host_u.wr_byte({SADDR, tt}, a);
    chk(24'(a), 24'h00_0001);
    for (int i = 0; i < n; i++) begin
      host_u.rd_byte(i < n - 1, d);
      chk(24'(d), 24'(e[i]));
    end
    host_u.stop();
  endtask
  task automatic t_unlock();
    wr_seq(TYPE_CMD_RD, '{0, 0, 0, 0}, 0, 8'h00, 0);
    host_u.stop();
    slave_addr_wr = 1'b1;
    slave_addr_data = SADDR;
    @(negedge sys_clk);
    slave_addr_wr = 1'b0;
    unlock_wr = 1'b1;
    unlock_data = 8'h92;
    @(negedge sys_clk);
    unlock_data = 8'h93;
    @(negedge sys_clk);
    unlock_wr = 1'b0;
    repeat (3749) @(negedge sys_clk);
    chk(24'(isp_active), 24'h00_0000);
    @(negedge sys_clk);
    chk(24'(isp_active), 24'h00_0001);
  endtask
  task automatic t_program();
    wr_seq(TYPE_CMD_WR, '{8'hd5, 0, 0, 0}, 1, 8'h03, 0);
    host_u.stop();
    wr_seq(TYPE_CMD_WR, '{8'ha3, 8'h12, 8'h00, 0}, 3, 8'h07, 0);
    host_u.stop();
    flash_wr_ready = 1'b0;
    wr_seq(TYPE_DATA_WR, '{8'h10, 8'hf6, 8'h28, 8'hc3}, 4, 8'h0f, 600);
    host_u.stop();
    chk(24'(flash_wr_valid), 24'h00_0001);
    flash_wr_ready = 1'b1;
    wr_seq(TYPE_DATA_WR, '{8'h12, 8'hc3, 8'h11, 0}, 3, 8'h07, 0);
    host_u.stop();
    rd_seq(TYPE_CMD_RD, '{8'ha3, 8'h12, 8'h13, 8'h70, 8'h31}, 5);
    chk(24'(wr_q.size()), 24'h00_0003);
    chk(wr_q[0], 24'h12_10f6);
    chk(wr_q[1], 24'h12_1128);
    chk(wr_q[2], 24'h12_12c3);
  endtask
  task automatic t_erase();
    logic [7:0] c;
    for (int k = 0; k < 2; k++) begin
      c = (k == 1) ? 8'h6b : 8'h31;
      wr_seq(TYPE_CMD_WR, '{c, 8'h12, 0, 0}, 2, 8'h07, 0);
      host_u.stop();
      wr_seq(TYPE_DATA_WR, '{8'h85, 8'h77, 8'h01, 0}, 3, 8'h07, 0);
      host_u.stop();
      chk(24'(er_cnt), 24'(k + 1));
      chk(24'(er_last[16]), 24'(k));
      if (k == 0) chk(24'(er_last[15:0]), 24'h00_1280);
      wr_seq(TYPE_CMD_RD, '{0, 0, 0, 0}, 0, 8'h00, 0);
      host_u.stop();
      host_u.wt(2200);
      rd_seq(TYPE_CMD_RD, '{c, 8'h12, 8'h86, 8'h70, 8'h31}, 5);
    end
  endtask
  task automatic t_read();
    wr_seq(TYPE_DATA_WR, '{8'h40, 0, 0, 0}, 1, 8'h03, 0);
    rd_seq(TYPE_DATA_RD, '{8'h1a, 8'h1b, 8'h18, 0, 0}, 3);
    rd_seq(TYPE_CMD_RD, '{8'h6b, 8'h12, 8'h43, 0, 0}, 3);
  endtask
  task automatic t_cpu_reset();
    wr_seq(TYPE_CMD_WR, '{8'h4c, 0, 0, 0}, 1, 8'h03, 0);
    host_u.stop();
    chk(24'(rst_cnt), 24'h00_0001);
    chk(24'(isp_active), 24'h00_0000);
    wr_seq(TYPE_CMD_RD, '{0, 0, 0, 0}, 0, 8'h00, 0);
    host_u.stop();
  endtask
  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst_cnt = 0;
    er_cnt = 0;
    rst_n = 1'b0;
    slave_addr_wr = 1'b0;
    slave_addr_data = 6'h00;
    unlock_wr = 1'b0;
    unlock_data = 8'h00;
    flash_wr_ready = 1'b1;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    host_u.wt(4);
    t_unlock();
    t_program();
    t_erase();
    t_read();
    t_cpu_reset();
    tally_and_finish();
  end
  initial begin
    #400_000;
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_i2c_isp_flash_programmer
